// ==== ads_pkg.sv ====
// How it works
// - docking capability bit resets set; software may clear it to disable docking.
// - after reset: attach and mated clear, switch off, dock codec held in reset.
// - same docking sequence for runtime dock and for resume from sleep states.
// - switch enable asserted on a low clock inside the eight zero command bits.
// - wait at least 2400 host clocks after switch enable before codec reset release.
// - codec reset released at least four bit clocks before the next frame sync.
// - codec serial input high on last sync bit of connect frame sets its status.
// - turnaround and address frames complete after connect detection.
// - mated flag set once initialization frames are complete.
// - docked: attach and mated set, switch enabled, codec reset released.
// - graceful and surprise undock are handled the same way.
// - on attach clear, codec reset asserted four bit clocks after frame end.
// - final frame sync is not suppressed when the codec reset asserts.
// - four bit clocks after codec reset, switch disabled at a quiet low point.
// - mated cleared after isolation; interrupt when mated status and enable set.
// - link reset asserted on platform reset or controller reset bit at zero.
// - either link reset clears attach and mated, disables switch, resets codec.
package ads_pkg;

////////////////////////////////////////////////////////////////////////////////
localparam logic [3:0] ADS_REG_CTRL = 4'h0;
localparam logic [3:0] ADS_REG_STATUS = 4'h4;
localparam logic [3:0] ADS_REG_CODEC = 4'h8;

localparam int ADS_CTRL_ATTACH = 0;
localparam int ADS_CTRL_CAP = 1;
localparam int ADS_CTRL_CONTROLLER_RESET_CTL_N = 2;
localparam int ADS_CTRL_DOCK_MATED_INT_ENABLE = 3;

localparam int ADS_STS_MATED = 0;
localparam int ADS_STS_DOCK_MATED_INT_STATUS = 1;
localparam int ADS_STS_SW_ON = 2;
localparam int ADS_STS_CONTROLLER_RESET_CTL_N_ON = 3;

localparam logic ADS_CAP_RST = 1'b1;
localparam logic ADS_CONTROLLER_RESET_CTL_N_RST = 1'b0;

localparam int ADS_HOST_WAIT_CLKS = 2400;
localparam logic [2:0] ADS_BCLK_GAP = 3'h4;
localparam logic [3:0] ADS_CMD_ZERO_BITS = 4'h8;
localparam int ADS_NUM_SDI = 2;

////////////////////////////////////////////////////////////////////////////////
typedef enum logic [8:0] {
    ADS_IDLE = 9'h001,
    ADS_EN_WAIT = 9'h002,
    ADS_HOST_WAIT = 9'h004,
    ADS_INIT = 9'h008,
    ADS_DOCKED = 9'h010,
    ADS_FRAME_END = 9'h020,
    ADS_RST_WAIT = 9'h040,
    ADS_ISO_WAIT = 9'h080,
    ADS_REL_WAIT = 9'h100
} ads_state_e;

typedef struct packed {
    logic bclk_rise;
    logic bclk_fall;
    logic sync_end;
    logic quiet;
    logic [1:0] sdi_last;
} ads_link_ev_s;

typedef struct packed {
    logic bclk_prev;
    logic sync_prev;
    logic [1:0] sdi_prev;
    logic [3:0] bit_idx;
} ads_trk_s;

typedef struct packed {
    ads_state_e st;
    logic attach;
    logic cap;
    logic controller_reset_ctl_n_n;
    logic dock_mated_int_enable;
    logic mated;
    logic dock_mated_int_status;
    logic [1:0] codec_sts;
    logic en_n;
    logic rst_n;
    logic link_rst_n;
    logic irq;
    logic [15:0] host_cnt;
    logic host_done;
    logic [2:0] bit_cnt;
    logic [1:0] frames;
    logic wait_r;
    logic [31:0] rdata;
} ads_seq_s;

endpackage

// ==== ads_sync2.sv ====
`timescale 1ns/10ps
`default_nettype none
module ads_sync2 #(
    parameter int W = 1
) (
    input wire logic clk_in,
    input wire logic rst_b_in,
    input wire logic [W-1:0] async_in,
    output logic [W-1:0] sync_out
);

    // first stage feeds only the second
    logic [W-1:0] meta_q;

    always_ff @(posedge clk_in or negedge rst_b_in)
    begin
        if (!rst_b_in)
        begin
            meta_q <= '0;
            sync_out <= '0;
        end
        else
        begin
            meta_q <= async_in;
            sync_out <= meta_q;
        end
    end

endmodule
`default_nettype wire

// ==== ads_frame_trk.sv ====
`timescale 1ns/10ps
`default_nettype none
module ads_frame_trk (
    input wire logic clk_in,
    input wire logic rst_b_in,
    input wire logic bclk_in,
    input wire logic sync_in,
    input wire logic sdo_in,
    input wire logic [1:0] sdi_in,
    output var ads_pkg::ads_link_ev_s ev_out
);
    import ads_pkg::*;

    ads_trk_s q;
    ads_trk_s d;

    always_comb
    begin
        d = q;
        ev_out.bclk_rise = bclk_in & ~q.bclk_prev;
        ev_out.bclk_fall = ~bclk_in & q.bclk_prev;
        ev_out.sync_end = ev_out.bclk_rise & ~sync_in & q.sync_prev;
        ev_out.sdi_last = q.sdi_prev;
        // first command bits are zero: a point where bit clock, sync and data out are low
        ev_out.quiet = ev_out.bclk_fall & ~sync_in & ~sdo_in
            & (q.bit_idx < ADS_CMD_ZERO_BITS);
        d.bclk_prev = bclk_in;
        if (ev_out.bclk_rise)
        begin
            d.sync_prev = sync_in;
            d.sdi_prev = sdi_in;
            if (ev_out.sync_end)
                d.bit_idx = 4'h0;
            else if (q.bit_idx != 4'hF)
                d.bit_idx = q.bit_idx + 4'h1;
        end
    end

    always_ff @(posedge clk_in or negedge rst_b_in)
    begin
        if (!rst_b_in)
            q <= '{bclk_prev: 1'b0, sync_prev: 1'b0, sdi_prev: 2'h0, bit_idx: 4'hF};
        else
            q <= d;
    end

endmodule
`default_nettype wire

// ==== ads_dock_seq.sv ====
`timescale 1ns/10ps
`default_nettype none
module ads_dock_seq #(
    parameter int HOST_WAIT_CLKS = ads_pkg::ADS_HOST_WAIT_CLKS
) (
    input wire logic clk_in,
    input wire logic rst_b_in,
    // avalon-mm slave
    input wire logic [3:0] address_in,
    input wire logic read_in,
    input wire logic write_in,
    input wire logic [31:0] writedata_in,
    input wire logic [3:0] byteenable_in,
    output logic [31:0] readdata_out,
    output logic waitrequest_out,
    // link pins, asynchronous to clk_in
    input wire logic link_bit_clock_in,
    input wire logic frame_sync_in,
    input wire logic serial_data_out_in,
    input wire logic [1:0] serial_data_in_in,
    // dock control pins
    output logic dock_switch_enable_n_out,
    output logic dock_codec_reset_n_out,
    output logic link_reset_n_out,
    output logic dock_mated_irq_out
);
    import ads_pkg::*;

    ////////////////////////////////////////////////////////////////////////////
    // link inputs synchronised, then edge and frame tracking

    logic [4:0] pins_s;
    ads_link_ev_s ev;

    ads_sync2 #(
        .W(5)
    ) u_sync (
        .clk_in(clk_in),
        .rst_b_in(rst_b_in),
        .async_in({link_bit_clock_in, frame_sync_in, serial_data_out_in,
            serial_data_in_in}),
        .sync_out(pins_s)
    );

    ads_frame_trk u_trk (
        .clk_in(clk_in),
        .rst_b_in(rst_b_in),
        .bclk_in(pins_s[4]),
        .sync_in(pins_s[3]),
        .sdo_in(pins_s[2]),
        .sdi_in(pins_s[1:0]),
        .ev_out(ev)
    );

    ////////////////////////////////////////////////////////////////////////////
    // state

    localparam logic [15:0] HOST_LAST = 16'(HOST_WAIT_CLKS - 1);

    ads_seq_s q;
    ads_seq_s d;

    logic wr_go;
    logic rd_go;
    logic wr_ctrl;
    logic wr_status;
    logic wr_codec;
    logic [31:0] rd_val;

    function automatic logic gap_done(input logic [2:0] cnt, input logic rise);
        gap_done = (cnt == ADS_BCLK_GAP) || ((cnt == ADS_BCLK_GAP - 3'h1) && rise);
    endfunction

    function automatic logic [2:0] gap_step(input logic [2:0] cnt, input logic rise);
        gap_step = (rise && cnt != ADS_BCLK_GAP) ? cnt + 3'h1 : cnt;
    endfunction

    // one decode shared by the write strobes
    function automatic logic reg_hit(input logic [3:0] addr, input logic [3:0] off);
        reg_hit = (addr == off);
    endfunction

    ////////////////////////////////////////////////////////////////////////////
    // bus decode: one wait cycle, answer on the second edge

    always_comb
    begin
        wr_go = write_in & ~q.wait_r & byteenable_in[0];
        rd_go = read_in & q.wait_r;
        wr_ctrl = wr_go && reg_hit(address_in, ADS_REG_CTRL);
        wr_status = wr_go && reg_hit(address_in, ADS_REG_STATUS);
        wr_codec = wr_go && reg_hit(address_in, ADS_REG_CODEC);
        rd_val = 32'h0000_0000;
        case (address_in)
            ADS_REG_CTRL:
            begin
                rd_val[ADS_CTRL_ATTACH] = q.attach;
                rd_val[ADS_CTRL_CAP] = q.cap;
                rd_val[ADS_CTRL_CONTROLLER_RESET_CTL_N] = q.controller_reset_ctl_n_n;
                rd_val[ADS_CTRL_DOCK_MATED_INT_ENABLE] = q.dock_mated_int_enable;
            end
            ADS_REG_STATUS:
            begin
                rd_val[ADS_STS_MATED] = q.mated;
                rd_val[ADS_STS_DOCK_MATED_INT_STATUS] = q.dock_mated_int_status;
                rd_val[ADS_STS_SW_ON] = ~q.en_n;
                rd_val[ADS_STS_CONTROLLER_RESET_CTL_N_ON] = ~q.rst_n;
            end
            ADS_REG_CODEC:
                rd_val[1:0] = q.codec_sts;
            default:
                rd_val = 32'h0000_0000;
        endcase
    end

    ////////////////////////////////////////////////////////////////////////////
    // next state

    always_comb
    begin
        d = q;
        d.wait_r = ~((read_in | write_in) & q.wait_r);
        if (rd_go)
            d.rdata = rd_val;

        // software side writes; clears first so hardware sets below win
        if (wr_ctrl)
        begin
            d.cap = writedata_in[ADS_CTRL_CAP];
            d.controller_reset_ctl_n_n = writedata_in[ADS_CTRL_CONTROLLER_RESET_CTL_N];
            d.dock_mated_int_enable = writedata_in[ADS_CTRL_DOCK_MATED_INT_ENABLE];
            // attach only taken while docking is supported
            d.attach = writedata_in[ADS_CTRL_ATTACH] & writedata_in[ADS_CTRL_CAP];
        end
        if (wr_status && writedata_in[ADS_STS_DOCK_MATED_INT_STATUS])
            d.dock_mated_int_status = 1'b0;
        if (wr_codec)
            d.codec_sts = q.codec_sts & ~writedata_in[1:0];
        if (!d.cap)
            d.attach = 1'b0;

        // host-clock wait runs free of the bit clock
        if (q.st == ADS_HOST_WAIT && !q.host_done)
        begin
            d.host_cnt = q.host_cnt + 16'h1;
            d.host_done = (q.host_cnt == HOST_LAST);
        end

        // a runtime dock and a resume both start from idle the same way
        case (q.st)
            ADS_IDLE:
            begin
                d.en_n = 1'b1;
                d.rst_n = 1'b0;
                if (q.attach)
                    d.st = ADS_EN_WAIT;
            end
            ADS_EN_WAIT:
            begin
                if (!q.attach)
                    d.st = ADS_IDLE;
                else if (ev.quiet)
                begin
                    d.en_n = 1'b0;
                    d.host_cnt = 16'h0;
                    d.host_done = 1'b0;
                    d.st = ADS_HOST_WAIT;
                end
            end
            ADS_HOST_WAIT:
            begin
                // codec still in reset: only isolation is left to do
                if (!q.attach)
                begin
                    d.bit_cnt = 3'h0;
                    d.st = ADS_ISO_WAIT;
                end
                // completion acted on at once, without waiting for a bit clock event
                else if (q.host_done)
                    d.st = ADS_REL_WAIT;
            end
            ADS_REL_WAIT:
            begin
                if (!q.attach)
                begin
                    d.bit_cnt = 3'h0;
                    d.st = ADS_ISO_WAIT;
                end
                // early in the frame, so the next sync is far more than four
                // bit clocks away
                else if (ev.quiet)
                begin
                    d.rst_n = 1'b1;
                    d.frames = 2'h0;
                    d.st = ADS_INIT;
                end
            end
            ADS_INIT:
            begin
                if (!q.attach)
                    d.st = ADS_FRAME_END;
                else if (ev.sync_end)
                begin
                    // connect, turnaround, address, then the address frame ends
                    if (q.frames == 2'h0)
                        d.codec_sts = d.codec_sts | ev.sdi_last;
                    d.frames = q.frames + 2'h1;
                    if (q.frames == 2'h3)
                    begin
                        d.mated = 1'b1;
                        d.dock_mated_int_status = 1'b1;
                        d.st = ADS_DOCKED;
                    end
                end
            end
            ADS_DOCKED:
            begin
                // a surprise removal looks like any other attach clear
                if (!q.attach)
                    d.st = ADS_FRAME_END;
            end
            ADS_FRAME_END:
            begin
                // frame sync is left running; the last sync is not skipped
                if (ev.sync_end)
                begin
                    d.bit_cnt = 3'h0;
                    d.st = ADS_RST_WAIT;
                end
            end
            ADS_RST_WAIT:
            begin
                d.bit_cnt = gap_step(q.bit_cnt, ev.bclk_rise);
                if (q.bit_cnt == ADS_BCLK_GAP && ev.bclk_fall)
                begin
                    d.rst_n = 1'b0;
                    d.bit_cnt = 3'h0;
                    d.st = ADS_ISO_WAIT;
                end
            end
            ADS_ISO_WAIT:
            begin
                d.bit_cnt = gap_step(q.bit_cnt, ev.bclk_rise);
                if (gap_done(q.bit_cnt, 1'b0) && ev.quiet)
                begin
                    d.en_n = 1'b1;
                    d.dock_mated_int_status = q.mated | d.dock_mated_int_status;
                    d.mated = 1'b0;
                    d.st = ADS_IDLE;
                end
            end
            default:
                d.st = ADS_IDLE;
        endcase

        // controller reset bit low holds the whole link in reset
        if (!q.controller_reset_ctl_n_n)
        begin
            d.st = ADS_IDLE;
            d.attach = d.attach & d.controller_reset_ctl_n_n;
            d.mated = 1'b0;
            d.en_n = 1'b1;
            d.rst_n = 1'b0;
        end
        d.link_rst_n = d.controller_reset_ctl_n_n;
        d.irq = d.dock_mated_int_status & d.dock_mated_int_enable;
    end

    ////////////////////////////////////////////////////////////////////////////
    // registers: platform reset gives the undocked state

    always_ff @(posedge clk_in or negedge rst_b_in)
    begin
        if (!rst_b_in)
        begin
            q <= '0;
            q.st <= ADS_IDLE;
            q.cap <= ADS_CAP_RST;
            q.controller_reset_ctl_n_n <= ADS_CONTROLLER_RESET_CTL_N_RST;
            q.en_n <= 1'b1;
            q.rst_n <= 1'b0;
            q.wait_r <= 1'b1;
        end
        else
            q <= d;
    end

    ////////////////////////////////////////////////////////////////////////////
    // outputs, each a flip-flop of the state

    always_comb
    begin
        readdata_out = q.rdata;
        waitrequest_out = q.wait_r;
        dock_switch_enable_n_out = q.en_n;
        dock_codec_reset_n_out = q.rst_n;
        link_reset_n_out = q.link_rst_n;
        dock_mated_irq_out = q.irq;
    end

endmodule
`default_nettype wire

// ==== ads_link_model.sv ====
`timescale 1ns/10ps
`default_nettype none
module ads_link_model (
    input wire logic en_n_in,
    input wire logic rst_n_in,
    output logic bclk_out,
    output logic sync_out,
    output logic sdo_out,
    output logic [1:0] sdi_out
);
    logic [4:0] bit_q = 5'h00;
    initial
    begin
        bclk_out = 1'b0;
        forever #80 bclk_out = ~bclk_out;
    end
    // short 24-bit frames keep the run brief; sync on the last 4 bits
    always @(posedge bclk_out)
        bit_q <= (bit_q == 5'h17) ? 5'h00 : bit_q + 5'h01;
    assign sync_out = (bit_q >= 5'h14);
    // command bits after the first eight toggle, so only early falls are quiet
    assign sdo_out = (bit_q >= 5'h08) && (bit_q < 5'h14) && bit_q[0];
    // codec 0 present; isolated or absent lines sit at the pull-down
    assign sdi_out = {1'b0, !en_n_in && rst_n_in && sync_out};
endmodule
`default_nettype wire

// ==== ads_dock_seq_chk.sv ====
`timescale 1ns/10ps
`default_nettype none
module ads_dock_seq_chk #(
    parameter int HOST_WAIT_CLKS = 2400
) (
    input wire logic clk_in,
    input wire logic rst_b_in,
    input wire logic read_in,
    input wire logic write_in,
    input wire logic waitrequest_out,
    input wire logic link_bit_clock_in,
    input wire logic frame_sync_in,
    input wire logic serial_data_out_in,
    input wire logic dock_switch_enable_n_out,
    input wire logic dock_codec_reset_n_out,
    input wire logic link_reset_n_out
);
    logic bclk_q;
    logic sync_q;
    logic rise;
    logic pend_q;
    logic [15:0] en_cnt_q;
    logic [3:0] rel_cnt_q;
    logic [3:0] sf_cnt_q;
    logic [3:0] ra_cnt_q;
    function automatic logic [3:0] inc4(input logic [3:0] v, input logic r);
        return v + {3'h0, r && (v != 4'hF)};
    endfunction
    assign rise = link_bit_clock_in && !bclk_q;
    always_ff @(posedge clk_in or negedge rst_b_in)
    begin
        if (!rst_b_in)
        begin
            bclk_q <= 1'b0;
            sync_q <= 1'b0;
            pend_q <= 1'b0;
            en_cnt_q <= 16'h0000;
            rel_cnt_q <= 4'h0;
            sf_cnt_q <= 4'h0;
            ra_cnt_q <= 4'h0;
        end
        else
        begin
            bclk_q <= link_bit_clock_in;
            sync_q <= frame_sync_in;
            pend_q <= !dock_codec_reset_n_out || (pend_q && !(frame_sync_in && !sync_q));
            en_cnt_q <= dock_switch_enable_n_out ? 16'h0000 :
                en_cnt_q + {15'h0000, en_cnt_q != 16'hFFFF};
            rel_cnt_q <= dock_codec_reset_n_out ? inc4(rel_cnt_q, rise) : 4'h0;
            ra_cnt_q <= dock_codec_reset_n_out ? 4'h0 : inc4(ra_cnt_q, rise);
            sf_cnt_q <= (sync_q && !frame_sync_in) ? 4'h0 : inc4(sf_cnt_q, rise);
        end
    end
    default clocking cb @(posedge clk_in); endclocking
    default disable iff (!rst_b_in);
    ////////////////////////////////////////////////////////////////////////////
    chk_bus_answer:
        assert property ((read_in || write_in) && waitrequest_out |=>
            !waitrequest_out ##1 waitrequest_out)
        else $error("bus answer not one cycle");
    chk_quiet_switch:
        assert property ($changed(dock_switch_enable_n_out) && link_reset_n_out |->
            !link_bit_clock_in && !frame_sync_in && !serial_data_out_in)
        else $error("switch moved outside a quiet point");
    chk_host_wait:
        assert property ($rose(dock_codec_reset_n_out) |->
            !dock_switch_enable_n_out && en_cnt_q >= HOST_WAIT_CLKS)
        else $error("codec reset released too early");
    chk_sync_gap:
        assert property (frame_sync_in && !sync_q && pend_q && dock_codec_reset_n_out |->
            rel_cnt_q >= 4'h4)
        else $error("sync too soon after codec reset release");
    chk_frame_end:
        assert property ($fell(dock_codec_reset_n_out) && link_reset_n_out |->
            sf_cnt_q >= 4'h4)
        else $error("codec reset asserted too soon after frame end");
    chk_iso_gap:
        assert property ($rose(dock_switch_enable_n_out) && link_reset_n_out |->
            !dock_codec_reset_n_out && ra_cnt_q >= 4'h4)
        else $error("switch released too soon after codec reset");
    chk_link_reset:
        assert property (!link_reset_n_out [*2] |->
            dock_switch_enable_n_out && !dock_codec_reset_n_out)
        else $error("link reset left dock connected");
    chk_iso_in_reset:
        assert property (dock_switch_enable_n_out |-> !dock_codec_reset_n_out)
        else $error("isolated codec out of reset");
    cover property ($fell(dock_switch_enable_n_out));
    cover property ($rose(dock_codec_reset_n_out));
    cover property ($rose(dock_switch_enable_n_out) && link_reset_n_out);
endmodule
bind ads_dock_seq ads_dock_seq_chk #(.HOST_WAIT_CLKS(HOST_WAIT_CLKS)) chk (
    .clk_in(clk_in),
    .rst_b_in(rst_b_in),
    .read_in(read_in),
    .write_in(write_in),
    .waitrequest_out(waitrequest_out),
    .link_bit_clock_in(link_bit_clock_in),
    .frame_sync_in(frame_sync_in),
    .serial_data_out_in(serial_data_out_in),
    .dock_switch_enable_n_out(dock_switch_enable_n_out),
    .dock_codec_reset_n_out(dock_codec_reset_n_out),
    .link_reset_n_out(link_reset_n_out)
);
`default_nettype wire

// ==== ads_dock_seq_test.sv ====
`timescale 1ns/10ps
`default_nettype none
module ads_dock_seq_test;
    import ads_pkg::*;
    // above one 8-bit quiet window, below one frame
    localparam int HW = 400;
    logic clk_in = 1'b0;
    logic rst_b_in;
    logic [3:0] address_in;
    logic read_in;
    logic write_in;
    logic [31:0] writedata_in;
    logic [3:0] byteenable_in;
    logic [31:0] readdata_out;
    logic waitrequest_out;
    logic bclk;
    logic sync;
    logic sdo;
    logic [1:0] sdi;
    logic en_n;
    logic drst_n;
    logic lrst_n;
    logic irq;
    int failures = 0;
    int checks = 0;
    always #2 clk_in = ~clk_in;
    ads_dock_seq #(.HOST_WAIT_CLKS(HW)) dut (
        .clk_in(clk_in),
        .rst_b_in(rst_b_in),
        .address_in(address_in),
        .read_in(read_in),
        .write_in(write_in),
        .writedata_in(writedata_in),
        .byteenable_in(byteenable_in),
        .readdata_out(readdata_out),
        .waitrequest_out(waitrequest_out),
        .link_bit_clock_in(bclk),
        .frame_sync_in(sync),
        .serial_data_out_in(sdo),
        .serial_data_in_in(sdi),
        .dock_switch_enable_n_out(en_n),
        .dock_codec_reset_n_out(drst_n),
        .link_reset_n_out(lrst_n),
        .dock_mated_irq_out(irq)
    );
    ads_link_model link (
        .en_n_in(en_n),
        .rst_n_in(drst_n),
        .bclk_out(bclk),
        .sync_out(sync),
        .sdo_out(sdo),
        .sdi_out(sdi)
    );
    ////////////////////////////////////////////////////////////////////////////
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        checks++;
        if (seen !== exp)
        begin
            failures++;
            $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic test_done();
        $display("checks %0d failures %0d", checks, failures);
        if (failures == 0 && checks > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask
    task automatic bus(input logic wr, input logic [3:0] a, input logic [31:0] d,
        output logic [31:0] q);
        int n;
        @(posedge clk_in);
        address_in <= a;
        writedata_in <= d;
        write_in <= wr;
        read_in <= !wr;
        n = 0;
        do
        begin
            @(posedge clk_in);
            n++;
        end
        while (waitrequest_out !== 1'b0 && n < 50);
        q = readdata_out;
        if (n >= 50)
        begin
            failures++;
            test_done();
        end
        read_in <= 1'b0;
        write_in <= 1'b0;
    endtask
    task automatic wr(input logic [3:0] a, input logic [31:0] d);
        logic [31:0] q;
        bus(1'b1, a, d, q);
    endtask
    task automatic rdm(input logic [3:0] a, input logic [31:0] m, input logic [31:0] e);
        logic [31:0] q;
        bus(1'b0, a, 32'h0, q);
        check(q & m, e);
    endtask
    task automatic pins(input logic en, input logic rst);
        check({30'h0, en_n, drst_n}, {30'h0, en, rst});
    endtask
    // status polling; running out of tries ends the run as a failure
    task automatic wait_sts(input int b, input logic v);
        logic [31:0] q;
        int n;
        n = 0;
        do
        begin
            bus(1'b0, ADS_REG_STATUS, 32'h0, q);
            n++;
        end
        while (q[b] !== v && n < 6000);
        if (q[b] !== v)
        begin
            failures++;
            test_done();
        end
    endtask
    initial
    begin
        rst_b_in = 1'b0;
        read_in = 1'b0;
        write_in = 1'b0;
        address_in = 4'h0;
        writedata_in = 32'h0;
        byteenable_in = 4'hF;
        repeat (5) @(posedge clk_in);
        rst_b_in <= 1'b1;
        rdm(ADS_REG_CTRL, 32'hF, 32'h2);
        rdm(ADS_REG_STATUS, 32'hF, 32'h8);
        rdm(ADS_REG_CODEC, 32'hF, 32'h0);
        rdm(4'hC, 32'hFFFFFFFF, 32'h0);
        check({31'h0, lrst_n}, 32'h0);
        pins(1'b1, 1'b0);
        $display("test reset done");
        wr(ADS_REG_CTRL, 32'h4);
        wr(ADS_REG_CTRL, 32'hF);
        wait_sts(ADS_STS_MATED, 1'b1);
        rdm(ADS_REG_STATUS, 32'hF, 32'h7);
        rdm(ADS_REG_CODEC, 32'hF, 32'h1);
        pins(1'b0, 1'b1);
        check({31'h0, irq}, 32'h1);
        wr(ADS_REG_STATUS, 32'h2);
        // irq moves at the commit edge; look one edge later
        @(posedge clk_in);
        check({31'h0, irq}, 32'h0);
        wr(ADS_REG_CODEC, 32'h1);
        $display("test dock done");
        wr(ADS_REG_CTRL, 32'hE);
        wait_sts(ADS_STS_SW_ON, 1'b0);
        rdm(ADS_REG_STATUS, 32'hF, 32'hA);
        check({31'h0, irq}, 32'h1);
        pins(1'b1, 1'b0);
        wr(ADS_REG_STATUS, 32'h2);
        $display("test undock done");
        wr(ADS_REG_CTRL, 32'hF);
        wait_sts(ADS_STS_SW_ON, 1'b1);
        wr(ADS_REG_CTRL, 32'hE);
        wait_sts(ADS_STS_SW_ON, 1'b0);
        rdm(ADS_REG_STATUS, 32'hD, 32'h8);
        pins(1'b1, 1'b0);
        wr(ADS_REG_STATUS, 32'h2);
        $display("test abort done");
        wr(ADS_REG_CTRL, 32'hF);
        wait_sts(ADS_STS_MATED, 1'b1);
        wr(ADS_REG_CTRL, 32'h3);
        rdm(ADS_REG_CTRL, 32'hF, 32'h2);
        rdm(ADS_REG_STATUS, 32'hD, 32'h8);
        check({31'h0, lrst_n}, 32'h0);
        pins(1'b1, 1'b0);
        check({31'h0, irq}, 32'h0);
        $display("test link reset done");
        wr(ADS_REG_CTRL, 32'h5);
        rdm(ADS_REG_CTRL, 32'hF, 32'h4);
        rdm(ADS_REG_STATUS, 32'hD, 32'h8);
        $display("test capability done");
        test_done();
    end
endmodule
`default_nettype wire
